// [hw/cwg_shutdown_steer.sv]
// Dead band, auto-shutdown and output steering of a complementary waveform generator
// Functional notes
// - Rising dead band held in bits 5..0
// - Falling dead band held in bits 5..0
// - Hardware sets shutdown flag bit 7
// - Software may set flag while disabled
// - Outputs stay shut until next waveform rise
// - Bit 6 enables automatic restart
// - B/D override: 11 high, 10 low, 01 float
// - B/D code 00: inactive level after band
// - A/C override: 11 high, 10 low, 01 float
// - A/C code 00: inactive level after band
// - Timers 6,4,2 enabled by bits 6,5,4
// - Comparators 2,1 enabled by bits 2,1
// - Input pin enabled by bit 0
// - Source-select bits 7 and 3 read one
// - Steer enable picks waveform or data bit
// - Data bits 7..4, enables bits 3..0
// - Steering applies only in modes 00x
// - Mode 001 double-buffers steering enables
// - Shutdown sources are level sensitive
// - Auto restart clears flag when sources low
// - Software clear needs all enabled sources low
// - Mode 000 steering, 001 synchronous steering
`include "cwg_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module cwg_shutdown_steer (
  // Clock and reset
  input  wire logic           clock,
  input  wire logic           rst,
  // Register port
  input  wire cwg_pkg::addr_t reg_addr,
  input  wire cwg_pkg::byte_t reg_wdata,
  input  wire logic           reg_write,
  input  wire logic           reg_read,
  output cwg_pkg::byte_t      reg_rdata,
  // Waveform and shutdown sources
  input  wire logic           generated_waveform,
  input  wire logic           waveform_input_pin,
  input  wire logic           timer6_post,
  input  wire logic           timer4_post,
  input  wire logic           timer2_post,
  input  wire logic           comparator2_out,
  input  wire logic           comparator1_out,
  // Output polarity from the neighbouring register
  input  wire logic [3:0]     output_invert,
  // Output pins A..D in bits 0..3
  output logic [3:0]          out_level,
  output logic [3:0]          out_enable
);
  import cwg_pkg::*;

  // Pin synchronisers, three stages each
  logic [2:0] pin_sync;       // Input pin
  logic [2:0] t6_sync;        // Timer 6
  logic [2:0] t4_sync;        // Timer 4
  logic [2:0] t2_sync;        // Timer 2
  logic [2:0] c2_sync;        // Comparator 2
  logic [2:0] c1_sync;        // Comparator 1
  logic [2:0] wav_sync;       // Generated waveform
  logic [6:0] src_state;      // Debounced levels

  // Register fields
  db_t   rise_deadband_value;   // Rising band
  db_t   fall_deadband_value;   // Falling band
  logic  shutdown_flag;         // Status flag
  logic  restart_enable;        // Auto restart
  logic [1:0] override_level_b_d;
  logic [1:0] override_level_a_c;
  logic [6:0] src_enable;       // Bits 6..4, 2..0 packed as stored
  byte_t steer_reg;             // Data and enables
  logic [3:0] steer_active;     // Enables in effect
  logic  module_en;             // Neighbouring enable
  logic  load_req;              // Buffer load request
  logic [2:0] mode;             // Operating mode
  logic  holding;               // Outputs held after clear
  logic  wave_prev;             // Waveform last cycle

  // Each source levels settle when stages two and three agree
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pin_sync <= 3'h0;
      t6_sync  <= 3'h0;
      t4_sync  <= 3'h0;
      t2_sync  <= 3'h0;
      c2_sync  <= 3'h0;
      c1_sync  <= 3'h0;
      wav_sync <= 3'h0;
    end else begin
      pin_sync <= {pin_sync[1:0], waveform_input_pin};
      t6_sync  <= {t6_sync[1:0], timer6_post};
      t4_sync  <= {t4_sync[1:0], timer4_post};
      t2_sync  <= {t2_sync[1:0], timer2_post};
      c2_sync  <= {c2_sync[1:0], comparator2_out};
      c1_sync  <= {c1_sync[1:0], comparator1_out};
      wav_sync <= {wav_sync[1:0], generated_waveform};
    end
  end

  // Agreement of stages two and three per source
  wire [6:0] agree_val = {wav_sync[2], t6_sync[2], t4_sync[2], t2_sync[2], c2_sync[2], c1_sync[2], pin_sync[2]};
  wire [6:0] agree_ok  = ~({wav_sync[2], t6_sync[2], t4_sync[2], t2_sync[2], c2_sync[2], c1_sync[2], pin_sync[2]} ^
                           {wav_sync[1], t6_sync[1], t4_sync[1], t2_sync[1], c2_sync[1], c1_sync[1], pin_sync[1]});

  // One flop per source takes the level once it is stable
  genvar gi;
  generate
    for (gi = 0; gi < 7; gi = gi + 1) begin : g_filter
      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          src_state[gi] <= 1'b0;
        end else if (agree_ok[gi]) begin
          src_state[gi] <= agree_val[gi];
        end
      end
    end
  endgenerate

  // Level-sensitive shutdown request from enabled sources
  wire [5:0] src_levels = src_state[5:0];  // t6,t4,t2,c2,c1,pin
  wire shut_request = |(src_levels & src_enable[5:0]);
  wire wave_now     = src_state[6];
  wire wave_rise    = wave_now & ~wave_prev;

  // Register decode
  wire wr_rise  = reg_write && (reg_addr == `REG_RISE_DB);
  wire wr_fall  = reg_write && (reg_addr == `REG_FALL_DB);
  wire wr_shut  = reg_write && (reg_addr == `REG_SHUT_CTRL);
  wire wr_src   = reg_write && (reg_addr == `REG_SHUT_SRC);
  wire wr_steer = reg_write && (reg_addr == `REG_STEER);
  wire wr_core  = reg_write && (reg_addr == `REG_CORE_CTRL);

  // Software writes to the flag: set only while disabled, clear only when sources quiet
  wire sw_set   = wr_shut && reg_wdata[`BIT_SHUTDOWN] && !module_en;
  wire sw_clear = wr_shut && !reg_wdata[`BIT_SHUTDOWN] && !shut_request;
  wire auto_clr = restart_enable && !shut_request;
  // Hardware set wins over any clear in the same cycle
  wire next_shutdown_flag = shut_request | sw_set | (shutdown_flag & ~(sw_clear | auto_clr));

  // Mode decode
  wire steer_mode = (mode[2:1] == 2'b00);
  wire sync_mode  = (mode == mode_sync_steer);

  // Configuration registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rise_deadband_value <= `RST_DB;
      fall_deadband_value <= `RST_DB;
      restart_enable      <= `RST_RESTART;
      override_level_b_d  <= `RST_OVR;
      override_level_a_c  <= `RST_OVR;
      src_enable          <= 7'h00;
      steer_reg           <= `RST_STEER;
      module_en           <= 1'b0;
      mode                <= 3'h0;
    end else begin
      if (wr_rise) rise_deadband_value <= reg_wdata[5:0];
      if (wr_fall) fall_deadband_value <= reg_wdata[5:0];
      if (wr_shut) begin
        restart_enable     <= reg_wdata[`BIT_RESTART];
        override_level_b_d <= reg_wdata[`FLD_BD_HI:`FLD_BD_LO];
        override_level_a_c <= reg_wdata[`FLD_AC_HI:`FLD_AC_LO];
      end
      if (wr_src) src_enable <= {1'b0, reg_wdata[6:4], reg_wdata[2:0]};
      if (wr_steer) steer_reg <= reg_wdata;
      if (wr_core) begin
        module_en <= reg_wdata[`BIT_EN];
        mode      <= reg_wdata[2:0];
      end
    end
  end

  // Shutdown flag, restart hold and buffered steering enables
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      shutdown_flag <= 1'b0;
      holding       <= 1'b0;
      wave_prev     <= 1'b0;
      load_req      <= 1'b0;
      steer_active  <= 4'h0;
    end else begin
      shutdown_flag <= next_shutdown_flag;
      wave_prev     <= wave_now;
      // Stay shut after the flag drops until the waveform rises
      if (next_shutdown_flag) holding <= 1'b1;
      else if (wave_rise) holding <= 1'b0;
      // Load request armed by software, only once enabled
      if (wr_core && reg_wdata[`BIT_LOAD] && module_en) load_req <= 1'b1;
      else if (wave_rise) load_req <= 1'b0;
      // Enables copy straight through unless synchronous steering
      if (!sync_mode) steer_active <= steer_reg[3:0];
      else if (wave_rise && load_req) steer_active <= steer_reg[3:0];
    end
  end

  // Dead-band shaping of the generated waveform
  logic db_wave;
  logic db_settled;
  deadband_delay u_delay (
    .clock      (clock),
    .rst        (rst),
    .wave_in    (wave_now),
    .rise_delay (rise_deadband_value),
    .fall_delay (fall_deadband_value),
    .wave_out   (db_wave),
    .settled    (db_settled)
  );

  // Per-output level selection
  logic [3:0] next_level;
  logic [3:0] next_enable;
  wire in_shutdown = shutdown_flag | holding;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_out
      wire [1:0] code   = ((gi % 2) == 1) ? override_level_b_d : override_level_a_c;
      wire       steered = steer_active[gi] ? (db_wave ^ output_invert[gi])
                                            : steer_reg[gi + 4];
      wire       normal  = steer_mode ? steered : (db_wave ^ output_invert[gi]);
      wire       inactive = output_invert[gi];  // Inactive level with polarity
      always_comb begin
        next_level[gi]  = normal;
        next_enable[gi] = module_en;
        if (in_shutdown) begin
          case (code)
            `OVR_HIGH:  next_level[gi] = 1'b1;
            `OVR_LOW:   next_level[gi] = 1'b0;
            `OVR_FLOAT: next_enable[gi] = 1'b0;
            default:    next_level[gi] = db_settled ? inactive : out_level[gi];
          endcase
        end
      end
    end
  endgenerate

  // Read mux, unmapped offsets read zero
  wire byte_t rd_shut  = {shutdown_flag, restart_enable, override_level_b_d, override_level_a_c, 2'b00};
  wire byte_t rd_src   = {1'b0, src_enable[5:3], 1'b0, src_enable[2:0]} | `SRC_ONES_MASK;
  wire byte_t rd_core  = {module_en, load_req, 3'b000, mode};
  wire byte_t rd_stat  = {1'b0, holding, 2'b00, src_state[6], 3'b000};
  wire byte_t rd_value = (reg_addr == `REG_RISE_DB)   ? {2'b00, rise_deadband_value} :
                         (reg_addr == `REG_FALL_DB)   ? {2'b00, fall_deadband_value} :
                         (reg_addr == `REG_SHUT_CTRL) ? rd_shut :
                         (reg_addr == `REG_SHUT_SRC)  ? rd_src :
                         (reg_addr == `REG_STEER)     ? steer_reg :
                         (reg_addr == `REG_CORE_CTRL) ? rd_core :
                         (reg_addr == `REG_STATUS)    ? rd_stat : 8'h00;

  // Registered outputs
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      reg_rdata  <= 8'h00;
      out_level  <= 4'h0;
      out_enable <= 4'h0;
    end else begin
      reg_rdata  <= reg_read ? rd_value : 8'h00;
      out_level  <= next_level;
      out_enable <= next_enable;
    end
  end
endmodule : cwg_shutdown_steer
`default_nettype wire

// [hw/cwg_cfg.svh]
// Offsets, field positions, reset values and override codes of the waveform block
`ifndef CWG_CFG_SVH
`define CWG_CFG_SVH
`define REG_RISE_DB      3'h0
`define REG_FALL_DB      3'h1
`define REG_SHUT_CTRL    3'h2
`define REG_SHUT_SRC     3'h3
`define REG_STEER        3'h4
`define REG_CORE_CTRL    3'h5
`define REG_STATUS       3'h6
`define BIT_SHUTDOWN     7
`define BIT_RESTART      6
`define FLD_BD_HI        5
`define FLD_BD_LO        4
`define FLD_AC_HI        3
`define FLD_AC_LO        2
`define BIT_EN           7
`define BIT_LOAD         6
`define RST_SHUT_CTRL    8'h14
`define RST_SRC          8'h00
`define RST_STEER        8'h00
`define RST_DB           6'h00
`define RST_CORE         8'h00
`define RST_RESTART      1'b0
`define RST_OVR          2'h1
`define SRC_ONES_MASK    8'h88
`define OVR_HIGH         2'h3
`define OVR_LOW          2'h2
`define OVR_FLOAT        2'h1
`define OVR_INACTIVE     2'h0
`endif

// [hw/cwg_pkg.sv]
// Types shared by the waveform block
package cwg_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [5:0] db_t;
  typedef logic [2:0] addr_t;
  typedef enum logic [2:0] {
    mode_steer      = 3'h0,
    mode_sync_steer = 3'h1,
    mode_other      = 3'h2
  } mode_e;
  typedef enum logic [2:0] {
    st_idle  = 3'b001,
    st_count = 3'b010,
    st_done  = 3'b100
  } db_state_e;
endpackage : cwg_pkg

// [hw/deadband_delay.sv]
// Dead-band delay: output follows input after a programmable count of clock periods
`timescale 1ns/1ps
`default_nettype none
module deadband_delay (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // Waveform in, delays and delayed out
  input  wire logic        wave_in,
  input  wire cwg_pkg::db_t rise_delay,
  input  wire cwg_pkg::db_t fall_delay,
  output logic             wave_out,
  output logic             settled
);
  import cwg_pkg::*;
  db_state_e state;         // Delay sequencer state
  db_t       count;         // Cycles still to wait
  logic      target;        // Level being waited for
  wire       edge_seen = (wave_in != target);  // Input moved
  wire db_t  load_val  = wave_in ? rise_delay : fall_delay;
  // Count the rising or falling dead band, then pass the level
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state    <= st_idle;
      count    <= 6'h00;
      target   <= 1'b0;
      wave_out <= 1'b0;
    end else begin
      case (state)
        st_idle, st_done: begin
          if (edge_seen) begin
            target <= wave_in;
            count  <= load_val;
            state  <= st_count;
          end
        end
        st_count: begin
          if (edge_seen) begin
            // Glitch shorter than the band restarts the wait
            target <= wave_in;
            count  <= load_val;
          end else if (count == 6'h00) begin
            wave_out <= target;
            state    <= st_done;
          end else begin
            count <= count - 6'h01;
          end
        end
        default: state <= st_idle;
      endcase
    end
  end
  // High once the output has caught up with the input
  assign settled = (state != st_count) && (wave_out == wave_in);
endmodule : deadband_delay
`default_nettype wire

// [verif/switch_driver_model.sv]
// Behavioural model of the bridge switch drivers hanging on the four output pins
`timescale 1ns/1ps
`default_nettype none
module switch_driver_model (
  // Clock
  input  wire logic       clock,
  // Pins from the block
  input  wire logic [3:0] out_level,
  input  wire logic [3:0] out_enable,
  // Level seen by each driver input
  output logic [3:0]      pin_level
);
  logic [3:0] last; // Last level actually driven per pin
  // Remember the driven level so a floating pin can show its opposite
  always_ff @(posedge clock) begin
    last <= (out_enable & out_level) | (~out_enable & last);
  end
  // A released pin has no pull, so it must not look like a held level
  assign pin_level = (out_enable & out_level) | (~out_enable & ~last);
endmodule : switch_driver_model
`default_nettype wire

// [verif/cwg_shutdown_steer_chk.sv]
// Port checker for the dead-band, shutdown and steering block
`timescale 1ns/1ps
`default_nettype none
module cwg_shutdown_steer_chk (
  // Clock and reset
  input wire logic           clock,
  input wire logic           rst,
  // Register port
  input wire cwg_pkg::addr_t reg_addr,
  input wire cwg_pkg::byte_t reg_wdata,
  input wire logic           reg_write,
  input wire logic           reg_read,
  input wire cwg_pkg::byte_t reg_rdata,
  // Waveform and sources
  input wire logic           generated_waveform,
  input wire logic           waveform_input_pin,
  input wire logic           timer6_post,
  input wire logic           timer4_post,
  input wire logic           timer2_post,
  input wire logic           comparator2_out,
  input wire logic           comparator1_out,
  input wire logic [3:0]     output_invert,
  // Pins
  input wire logic [3:0]     out_level,
  input wire logic [3:0]     out_enable
);
  logic [3:0] ovr;     // Shadow of both override codes
  logic [6:0] sel;     // Shadow of source enables
  logic       core_en; // Shadow of core enable
  logic [3:0] hi_cnt;  // Cycles since last write with an enabled source high
  wire logic  src_hi = |(sel & {timer6_post, timer4_post, timer2_post, 1'b0, comparator2_out, comparator1_out,
                                waveform_input_pin});
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // Track register writes that steer the outputs
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ovr     <= 4'h5;
      sel     <= 7'h00;
      core_en <= 1'b0;
    end else if (reg_write) begin
      if (reg_addr == 3'h2) ovr <= reg_wdata[5:2];
      if (reg_addr == 3'h3) sel <= reg_wdata[6:0];
      if (reg_addr == 3'h5) core_en <= reg_wdata[7];
    end
  end
  // Count settled shutdown cycles, restarting after any write
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      hi_cnt <= 4'h0;
    end else if (reg_write || !src_hi) begin
      hi_cnt <= 4'h0;
    end else if (hi_cnt != 4'hF) begin
      hi_cnt <= hi_cnt + 4'h1;
    end
  end
  property p_rd_idle; !reg_read |=> reg_rdata == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_src_ones; reg_read && reg_addr == 3'h3 |=> reg_rdata[7] && reg_rdata[3]; endproperty
  a_src_ones: assert property (p_src_ones) else $error("select spare bits not one");
  property p_rise_top; reg_read && reg_addr == 3'h0 |=> reg_rdata[7:6] == 2'h0; endproperty
  a_rise_top: assert property (p_rise_top) else $error("rise band upper bits");
  property p_fall_top; reg_read && reg_addr == 3'h1 |=> reg_rdata[7:6] == 2'h0; endproperty
  a_fall_top: assert property (p_fall_top) else $error("fall band upper bits");
  property p_pair; out_enable[0] == out_enable[2] && out_enable[1] == out_enable[3]; endproperty
  a_pair: assert property (p_pair) else $error("pin pair enables differ");
  property p_off; !core_en [*2] |-> out_enable == 4'h0; endproperty
  a_off: assert property (p_off) else $error("pins driven while disabled");
  property p_flt_ac; hi_cnt >= 4'h8 && ovr[1:0] == 2'h1 |-> !out_enable[0]; endproperty
  a_flt_ac: assert property (p_flt_ac) else $error("A/C not floating");
  property p_flt_bd; hi_cnt >= 4'h8 && ovr[3:2] == 2'h1 |-> !out_enable[1]; endproperty
  a_flt_bd: assert property (p_flt_bd) else $error("B/D not floating");
  property p_hi_ac; hi_cnt >= 4'h8 && core_en && ovr[1:0] == 2'h3 |-> out_enable[0] && out_level[0] && out_level[2];
  endproperty
  a_hi_ac: assert property (p_hi_ac) else $error("A/C not high");
  property p_lo_bd; hi_cnt >= 4'h8 && core_en && ovr[3:2] == 2'h2 |-> out_enable[1] && !out_level[1] && !out_level[3];
  endproperty
  a_lo_bd: assert property (p_lo_bd) else $error("B/D not low");
  c_shut: cover property (hi_cnt >= 4'h8 && core_en);
  c_sel: cover property (reg_read && reg_addr == 3'h3);
  c_run: cover property (core_en && out_enable == 4'hF);
endmodule : cwg_shutdown_steer_chk
bind cwg_shutdown_steer cwg_shutdown_steer_chk u_cwg_shutdown_steer_chk (.clock(clock), .rst(rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .generated_waveform(generated_waveform), .waveform_input_pin(waveform_input_pin), .timer6_post(timer6_post),
  .timer4_post(timer4_post), .timer2_post(timer2_post), .comparator2_out(comparator2_out),
  .comparator1_out(comparator1_out), .output_invert(output_invert), .out_level(out_level), .out_enable(out_enable));
`default_nettype wire

// [verif/waveform_deadband_shutdown_steering_bench.sv]
// Self-checking bench for the dead-band, shutdown and steering block
`timescale 1ns/1ps
`default_nettype none
module waveform_deadband_shutdown_steering_bench;
  import cwg_pkg::*;
  logic       clock, rst, reg_write, reg_read, generated_waveform;
  addr_t      reg_addr;
  byte_t      reg_wdata, reg_rdata;
  logic [6:0] src; // Sources in source-select bit order
  logic [3:0] output_invert, out_level, out_enable, pin_level;
  int         error_cnt, n_checks;
  cwg_shutdown_steer u_cwg_shutdown_steer (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .generated_waveform(generated_waveform),
    .waveform_input_pin(src[0]), .timer6_post(src[6]), .timer4_post(src[5]), .timer2_post(src[4]),
    .comparator2_out(src[2]), .comparator1_out(src[1]), .output_invert(output_invert), .out_level(out_level),
    .out_enable(out_enable));
  switch_driver_model u_switch_driver_model (.clock(clock), .out_level(out_level), .out_enable(out_enable),
    .pin_level(pin_level));
  // Compare and report
  task automatic chk(input byte_t got, input byte_t exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // One-cycle register write
  task automatic wr(input addr_t a, input byte_t d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask : wr
  // One-cycle register read, masked compare of the data in the next cycle
  task automatic rd(input addr_t a, input byte_t m, input byte_t e);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 chk(reg_rdata & m, e);
  endtask : rd
  // Wait whole cycles, then step past the edge
  task automatic idle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : idle
  // Reset values, implemented bits and an unmapped place
  task automatic t_regs;
    rd(3'h2, 8'hFF, 8'h14);
    rd(3'h3, 8'hFF, 8'h88);
    wr(3'h0, 8'hFF);
    rd(3'h0, 8'hFF, 8'h3F);
    wr(3'h1, 8'hEA);
    rd(3'h1, 8'hFF, 8'h2A);
    wr(3'h4, 8'hA5);
    rd(3'h4, 8'hFF, 8'hA5);
    wr(3'h7, 8'hFF);
    rd(3'h7, 8'hFF, 8'h00);
    wr(3'h0, 8'h00);
    wr(3'h1, 8'h00);
  endtask : t_regs
  // Software set of the flag only while disabled
  task automatic t_swflag;
    wr(3'h2, 8'h94);
    rd(3'h2, 8'h80, 8'h80);
    wr(3'h5, 8'h80);
    wr(3'h2, 8'h14);
    wr(3'h2, 8'h94);
    rd(3'h2, 8'h80, 8'h00);
    wr(3'h5, 8'h00);
  endtask : t_swflag
  // Each source alone, a refused clear while it is high, then disabled sources
  task automatic t_sources;
    for (int b = 0; b < 7; b++) begin
      if (b != 3) begin
        wr(3'h3, 8'h01 << b);
        @(posedge clock);
        src[b] <= 1'b1;
        idle(8);
        rd(3'h2, 8'h80, 8'h80);
        wr(3'h2, 8'h14);
        rd(3'h2, 8'h80, 8'h80);
        @(posedge clock);
        src[b] <= 1'b0;
        idle(8);
        wr(3'h2, 8'h14);
        rd(3'h2, 8'h80, 8'h00);
      end
    end
    wr(3'h3, 8'h00);
    @(posedge clock);
    src <= 7'h7F;
    idle(8);
    rd(3'h2, 8'h80, 8'h00);
    @(posedge clock);
    src <= 7'h00;
    idle(8);
  endtask : t_sources
  // Automatic restart clears the flag once the source drops
  task automatic t_restart;
    wr(3'h3, 8'h10);
    wr(3'h2, 8'h54);
    @(posedge clock);
    src[4] <= 1'b1;
    idle(8);
    rd(3'h2, 8'hC0, 8'hC0);
    @(posedge clock);
    src[4] <= 1'b0;
    idle(8);
    rd(3'h2, 8'hC0, 8'h40);
  endtask : t_restart
  // Override codes per pin pair, polarity set to show codes 11 and 10 ignore it and code 00 follows it
  task automatic t_override;
    byte_t ctl[4] = '{8'h38, 8'h2C, 8'h14, 8'h00};
    byte_t exp[4] = '{8'hFA, 8'hF5, 8'h00, 8'hF5};
    wr(3'h5, 8'h80);
    @(posedge clock);
    output_invert <= 4'h5;
    for (int i = 0; i < 4; i++) begin
      wr(3'h2, ctl[i]);
      @(posedge clock);
      src[4] <= 1'b1;
      idle(8);
      chk({out_enable, pin_level & out_enable}, exp[i]);
      @(posedge clock);
      src[4] <= 1'b0;
      idle(8);
    end
  endtask : t_override
  // Held shutdown until a rise, then plain and synchronous steering
  task automatic t_steer;
    wr(3'h4, 8'hA0);
    wr(3'h2, 8'h14);
    idle(8);
    chk({4'h0, out_enable}, 8'h00);
    @(posedge clock);
    generated_waveform <= 1'b1;
    idle(80);
    chk({out_enable, out_level}, 8'hFA);
    wr(3'h4, 8'h0F);
    @(posedge clock);
    output_invert <= 4'h3;
    idle(80);
    chk({4'h0, out_level}, 8'h0C);
    // Falling band of 20 holds the old level well past the sync delay
    wr(3'h1, 8'h14);
    @(posedge clock);
    generated_waveform <= 1'b0;
    idle(10);
    chk({4'h0, out_level}, 8'h0C);
    idle(70);
    chk({4'h0, out_level}, 8'h03);
    wr(3'h5, 8'h81);
    wr(3'h4, 8'hF0);
    idle(8);
    chk({4'h0, out_level}, 8'h03);
    wr(3'h5, 8'hC1);
    @(posedge clock);
    generated_waveform <= 1'b1;
    idle(80);
    chk({4'h0, out_level}, 8'h0F);
    // A mode outside 00x ignores the steering data
    wr(3'h5, 8'h82);
    idle(4);
    chk({4'h0, out_level}, 8'h0C);
  endtask : t_steer
  // Counts and verdict
  task automatic end_sim;
    $display("checks=%0d errors=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_sim
  // Clock
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  // Main sequence
  initial begin
    rst = 1'b1;
    {reg_write, reg_read, generated_waveform} = 3'h0;
    {reg_addr, reg_wdata, src, output_invert} = '0;
    {error_cnt, n_checks} = '0;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    t_regs;
    t_swflag;
    t_sources;
    t_restart;
    t_override;
    t_steer;
    end_sim;
  end
  // Watchdog
  initial begin
    repeat (20000) @(posedge clock);
    error_cnt++;
    end_sim;
  end
endmodule : waveform_deadband_shutdown_steering_bench
`default_nettype wire
